//--- adcc_ctrl.sv
// A/D command register, result bytes, channel scan range, gain and scan setup.
// Assumes a host byte port synchronous to clk and a converter with start/done.
// Summary of operation
// R1 - Command bits are self-clearing triggers; several may fire in one write.
// R2 - Bit7 start, 6 board reset, 5 dac reset, 4 fifo clear, 3..0 request clears.
// R3 - Software start raises conversion active until the result is ready.
// R4 - With analog interrupt enabled, start command ignored; selected source triggers.
// R5 - Board reset zeroes registers, ports to input, stops activity, keeps dac.
// R6 - Dac reset returns outputs to mid or zero scale per config input.
// R7 - Fifo clear sets sample count to zero.
// R8 - Each request clear bit resets only its own request flag.
// R9 - Requests stay set until cleared by software.
// R10 - Result low byte at offset 0, high byte at offset 1.
// R11 - Writes to offset 1 do nothing.
// R12 - Channel register: upper bound bits 7-4, lower bound bits 3-0.
// R13 - Software keeps upper bound not below lower bound.
// R14 - Channel write loads current channel with lower bound; a result taken in the same cycle advances it instead.
// R15 - Channel or gain write raises settling wait for 10 us.
// R16 - Settling wait timed from the most recent such write.
// R17 - Channel advances after each conversion, wrapping to lower bound.
// R18 - Channel register reads back last written value.
// R19 - Scan mode converts every channel in range; active whole scan.
// R20 - Single mode converts current channel only, then advances.
// R21 - Gain code bits 1-0 of offset 3, scan enable bit 2.
// R22 - Unused readable bits return zero.
// R23 - Trigger select: 0 timer output, 1 external trigger, when interrupts on.
// R24 - Status reports active, settling, mode, overflow, scan and gain.
// R25 - Settling counter runs on clk and reloads on each channel or setup write.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Host byte port
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Shared controls from the interrupt and counter registers
  input  wire logic       analog_irq_enable,
  input  wire logic       trigger_source_select,
  input  wire logic       timer0_tick,
  input  wire logic       ext_trigger_pin,
  input  wire logic       ended_mode_flag,
  input  wire logic       dac_midscale_cfg,
  input  wire logic       dac_busy,
  input  wire logic       fifo_overflow,
  // Request sources set by neighbouring circuits
  input  wire logic [3:0] request_set,
  // Converter handshake
  input  wire logic       conv_done,
  input  wire logic [15:0] conv_result,
  output logic            conv_start,
  output logic      [3:0] current_channel,
  output logic      [1:0] input_gain_sel,
  // Side effects toward neighbours
  output logic      [3:0] request_flags,
  output logic      [5:0] sample_count,
  output logic            board_reset_cmd,
  output logic            dac_reset_cmd,
  output logic            dac_reset_midscale,
  output logic            conversion_active,
  output logic            settling_wait
);
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] ext_sync;
  logic       ext_prev;
  logic [15:0] sample;
  logic [7:0]  chan_reg;
  logic        sweep_mode_on;
  logic [9:0]  settle_cnt;
  logic        sweep_last;
  logic [15:0] next_sample;
  logic [7:0]  next_chan_reg;
  logic [3:0]  next_channel;
  logic [1:0]  next_gain;
  logic        next_sweep;
  logic [9:0]  next_settle_cnt;
  logic        next_active;
  logic        next_start;
  logic [3:0]  next_requests;
  logic [5:0]  next_count;
  logic        next_board_reset;
  logic        next_dac_reset;
  logic        next_midscale;
  logic        next_sweep_last;
  logic [7:0]  next_rdata;
  logic [7:0]  cmd;
  logic        hw_trigger;
  logic        trigger;
  logic [3:0]  upper_channel_bound;
  logic [3:0]  lower_channel_bound;
  logic [1:0]  mid_sync;
  logic [1:0]  sd_sync;
  logic [1:0]  next_ext_sync;
  logic        next_ext_prev;
  logic [1:0]  next_mid_sync;
  logic [1:0]  next_sd_sync;
  logic        next_settling;
  logic        chan_write;
  logic        setup_write;
  logic        board_reset_req;
  logic        conv_taken;

  function automatic logic [3:0] adcc_advance(input logic [3:0] ch, input logic [3:0] lo,
                                                input logic [3:0] hi);
    adcc_advance = (ch == hi) ? lo : 4'(ch + 4'h1);
  endfunction

  // Reset release through two flip-flops.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign upper_channel_bound = chan_reg[7:4]; // [R12]
  assign lower_channel_bound = chan_reg[3:0]; // [R12]
  assign cmd = (wr && addr == adcc_pkg::OFS_CMD_DATA) ? wdata : adcc_pkg::RESET_BYTE; // [R1]
  // Hardware trigger source when interrupts are enabled; edge of the synchronised pin.
  assign hw_trigger = analog_irq_enable &&
                      (trigger_source_select ? (ext_sync[1] && !ext_prev) : timer0_tick); // [R23]
  assign trigger = analog_irq_enable ? hw_trigger : cmd[adcc_pkg::BIT_CONV_TRIGGER]; // [R3] [R4]
  assign chan_write      = wr && addr == adcc_pkg::OFS_CHANNEL;
  assign setup_write     = wr && addr == adcc_pkg::OFS_SETUP;
  assign board_reset_req = cmd[adcc_pkg::BIT_BOARD_RESET]; // [R2]
  assign conv_taken      = conversion_active && conv_done;

  // Pin-side inputs pass two flip-flops before any logic reads them.
  always_comb begin
    next_ext_sync = {ext_sync[0], ext_trigger_pin};
    next_ext_prev = ext_sync[1];
    next_mid_sync = {mid_sync[0], dac_midscale_cfg};
    next_sd_sync  = {sd_sync[0], ended_mode_flag};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync <= 2'b00;
      ext_prev <= 1'b0;
      mid_sync <= 2'b00;
      sd_sync  <= 2'b00;
    end else begin
      ext_sync <= next_ext_sync;
      ext_prev <= next_ext_prev;
      mid_sync <= next_mid_sync;
      sd_sync  <= next_sd_sync;
    end
  end

  // Channel range, gain, scan enable and the settling counter.
  always_comb begin
    next_chan_reg   = chan_reg;
    next_gain       = input_gain_sel;
    next_sweep      = sweep_mode_on;
    next_settle_cnt = (settle_cnt != 10'h000) ? 10'(settle_cnt - 10'h001) : settle_cnt;
    if (chan_write) begin
      next_chan_reg   = wdata; // [R18]
      next_settle_cnt = adcc_pkg::SETTLE_LOAD; // [R15] [R16] [R25]
    end
    if (setup_write) begin
      next_gain       = wdata[1:0]; // [R21]
      next_sweep      = wdata[adcc_pkg::BIT_SWEEP]; // [R21]
      next_settle_cnt = adcc_pkg::SETTLE_LOAD; // [R15] [R16] [R25]
    end
    if (board_reset_req) begin
      next_chan_reg   = adcc_pkg::RESET_BYTE; // [R5]
      next_gain       = 2'b00;
      next_sweep      = 1'b0;
      next_settle_cnt = 10'h000;
    end
    next_settling = next_settle_cnt != 10'h000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_reg       <= adcc_pkg::RESET_BYTE;
      input_gain_sel <= 2'b00;
      sweep_mode_on  <= 1'b0;
      settle_cnt     <= 10'h000;
      settling_wait  <= 1'b0;
    end else begin
      chan_reg       <= next_chan_reg;
      input_gain_sel <= next_gain;
      sweep_mode_on  <= next_sweep;
      settle_cnt     <= next_settle_cnt;
      settling_wait  <= next_settling;
    end
  end

  // Conversion sequencing: start pulse, scan progress, channel pointer and result.
  always_comb begin
    next_sample     = sample;
    next_channel    = current_channel;
    next_active     = conversion_active;
    next_start      = 1'b0;
    next_sweep_last = sweep_last;
    next_count      = sample_count;
    if (chan_write) begin
      next_channel = wdata[3:0]; // [R14]
    end
    if (!conversion_active && trigger) begin
      next_active     = 1'b1; // [R3]
      next_start      = 1'b1;
      next_sweep_last = !sweep_mode_on || (current_channel == upper_channel_bound);
    end else if (conv_taken) begin
      next_sample  = conv_result;
      next_channel = adcc_advance(current_channel, lower_channel_bound,
                                  upper_channel_bound); // [R17]
      if (sweep_last) begin
        next_active = 1'b0; // [R20]
      end else begin
        next_start      = 1'b1; // [R19]
        next_sweep_last = (next_channel == upper_channel_bound);
      end
    end
    if (cmd[adcc_pkg::BIT_BUFFER_CLEAR]) begin
      next_count = adcc_pkg::RESET_DEPTH; // [R7]
    end else if (conv_taken && sample_count != 6'h3f) begin
      next_count = 6'(sample_count + 6'h01);
    end
    if (board_reset_req) begin
      next_sample     = 16'h0000; // [R5]
      next_channel    = 4'h0;
      next_active     = 1'b0;
      next_start      = 1'b0;
      next_count      = adcc_pkg::RESET_DEPTH;
      next_sweep_last = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample            <= 16'h0000;
      current_channel   <= 4'h0;
      conversion_active <= 1'b0;
      conv_start        <= 1'b0;
      sweep_last        <= 1'b0;
      sample_count      <= adcc_pkg::RESET_DEPTH;
    end else begin
      sample            <= next_sample;
      current_channel   <= next_channel;
      conversion_active <= next_active;
      conv_start        <= next_start;
      sweep_last        <= next_sweep_last;
      sample_count      <= next_count;
    end
  end

  // Request flags: clear bits act per flag, and a same-cycle set wins.
  always_comb begin
    next_requests = (request_flags & ~cmd[3:0]) | request_set; // [R8] [R9]
    if (board_reset_req) begin
      next_requests = 4'h0; // [R5]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      request_flags <= 4'h0;
    end else begin
      request_flags <= next_requests;
    end
  end

  // One-cycle command pulses and the synchronised midscale level toward the neighbouring circuits.
  always_comb begin
    next_board_reset = board_reset_req; // [R5]
    next_dac_reset   = cmd[adcc_pkg::BIT_DAC_RESET]; // [R6]
    next_midscale    = mid_sync[1]; // [R6]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      board_reset_cmd    <= 1'b0;
      dac_reset_cmd      <= 1'b0;
      dac_reset_midscale <= 1'b0;
    end else begin
      board_reset_cmd    <= next_board_reset;
      dac_reset_cmd      <= next_dac_reset;
      dac_reset_midscale <= next_midscale;
    end
  end

  // Read mux; offset 1 writes fall through untouched.
  always_comb begin
    case (addr) // [R11]
      adcc_pkg::OFS_CMD_DATA:  next_rdata = sample[7:0]; // [R10]
      adcc_pkg::OFS_DATA_HIGH: next_rdata = sample[15:8]; // [R10]
      adcc_pkg::OFS_CHANNEL:   next_rdata = chan_reg;
      adcc_pkg::OFS_SETUP:     next_rdata = {conversion_active, sd_sync[1],
                                             settling_wait, dac_busy, fifo_overflow,
                                             sweep_mode_on, input_gain_sel}; // [R24] [R22]
      default:                 next_rdata = 8'h00;
    endcase
    if (!rd) begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= adcc_pkg::RESET_BYTE;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule // adcc_ctrl
`default_nettype wire

//--- adcc_pkg.sv
// Constants shared by the A/D command and scan control block.
// Assumes a 100 MHz system clock and an 8-bit I/O byte port.
package adcc_pkg;
  localparam logic [1:0] OFS_CMD_DATA  = 2'h0;
  localparam logic [1:0] OFS_DATA_HIGH = 2'h1;
  localparam logic [1:0] OFS_CHANNEL   = 2'h2;
  localparam logic [1:0] OFS_SETUP     = 2'h3;
  localparam int BIT_CONV_TRIGGER   = 7;
  localparam int BIT_BOARD_RESET    = 6;
  localparam int BIT_DAC_RESET      = 5;
  localparam int BIT_BUFFER_CLEAR   = 4;
  localparam int BIT_DMA_CLEAR      = 3;
  localparam int BIT_TIMER_CLEAR    = 2;
  localparam int BIT_DIO_CLEAR      = 1;
  localparam int BIT_ANALOG_CLEAR   = 0;
  localparam int BIT_SWEEP          = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [5:0] RESET_DEPTH = 6'h00;
  localparam int CLK_MHZ            = 100;
  localparam int SETTLE_US          = 10;
  localparam int SETTLE_CYCLES      = SETTLE_US * CLK_MHZ;
  localparam logic [9:0] SETTLE_LOAD = 10'(SETTLE_CYCLES);
endpackage

//--- adcc_ctrl_asserts.sv
// Port checks for the A/D control block.
// Bound to adcc_ctrl; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_asserts (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Watched ports
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       analog_irq_enable,
  input wire logic       conv_start,
  input wire logic [3:0] current_channel,
  input wire logic [1:0] input_gain_sel,
  input wire logic       board_reset_cmd,
  input wire logic       conversion_active,
  input wire logic       settling_wait
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic        cw;
  logic [10:0] age;
  assign cw = wr && addr == 2'h0;
  // Edges since the last channel or setup write; zero when a board reset voids it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) age <= 11'h0;
    else if (cw && wdata[6]) age <= 11'h0;
    else if (wr && addr[1]) age <= 11'h1;
    else if (age != 11'h0 && age != 11'h7ff) age <= age + 11'h1;
  end
  a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start too long");
  a_soft_trigger: assert property (cw && wdata[7] && !wdata[6] && !analog_irq_enable
    && !conversion_active |=> conv_start && conversion_active) else $error("start lost");
  a_irq_blocks: assert property (cw && wdata[7] && analog_irq_enable && !conversion_active
    |=> !conv_start) else $error("start taken");
  a_settle_span: assert property (age != 11'h0 && age < 11'(adcc_pkg::SETTLE_CYCLES)
    |-> settling_wait) else $error("settling ended early");
  a_chan_load: assert property (wr && addr == 2'h2 && !conversion_active
    |=> current_channel == $past(wdata[3:0])) else $error("channel not loaded");
  a_gain_apply: assert property (wr && addr == 2'h3
    |=> input_gain_sel == $past(wdata[1:0])) else $error("gain not applied");
  a_ofs1_inert: assert property (wr && addr == 2'h1 && !conversion_active
    |=> $stable(current_channel) && $stable(input_gain_sel) && !conv_start
    && !$rose(settling_wait)) else $error("offset one write acted");
  a_board_reset: assert property (cw && wdata[6] |=> board_reset_cmd ##1 (!conversion_active
    && current_channel == 4'h0 && input_gain_sel == 2'h0)) else $error("board reset incomplete");
endmodule // adcc_ctrl_asserts
bind adcc_ctrl adcc_ctrl_asserts adcc_ctrl_asserts_i (.clk(clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr(wr), .analog_irq_enable(analog_irq_enable), .conv_start(conv_start),
  .current_channel(current_channel), .input_gain_sel(input_gain_sel),
  .board_reset_cmd(board_reset_cmd), .conversion_active(conversion_active),
  .settling_wait(settling_wait));
`default_nettype wire

//--- adcc_conv_model.sv
// Converter model: answers each start with a result six cycles later.
// Assumes conv_start is a one-cycle pulse on clk.
`timescale 1ns/1ps
`default_nettype none
module adcc_conv_model (
  // Converter handshake
  input  wire logic        clk,
  input  wire logic        conv_start,
  input  wire logic [3:0]  current_channel,
  output logic             conv_done = 1'b0,
  output logic      [15:0] conv_result = 16'h0
);
  int left = 0;
  // Off the done cycle the result bus toggles, so a late capture shows up.
  always @(posedge clk) begin
    conv_done <= left == 1;
    conv_result <= (left == 1) ? {current_channel, 12'h3c5} : ~conv_result;
    left <= conv_start ? 5 : (left > 0 ? left - 1 : 0);
  end
endmodule // adcc_conv_model
`default_nettype wire

//--- adcc_ctrl_tb.sv
// Bench for adcc_ctrl: host byte accesses and a converter model.
// Assumes strobes driven at the falling edge, one access per two cycles.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_tb;
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, irq = 1'b0;
  logic        start, done, busy, settle, brst, drst, dmid;
  logic [1:0]  addr = 2'h0, gain;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [3:0]  rset = 4'h0, chan, flags;
  logic [5:0]  count;
  logic [15:0] res;
  int          fail_count = 0, checks_done = 0;
  adcc_ctrl adcc_ctrl_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .analog_irq_enable(irq), .trigger_source_select(1'b0), .timer0_tick(1'b0),
    .ext_trigger_pin(1'b0), .ended_mode_flag(nrst), .dac_midscale_cfg(irq), .dac_busy(1'b0),
    .fifo_overflow(1'b0), .request_set(rset), .conv_done(done), .conv_result(res),
    .conv_start(start), .current_channel(chan), .input_gain_sel(gain), .request_flags(flags),
    .sample_count(count), .board_reset_cmd(brst), .dac_reset_cmd(drst),
    .dac_reset_midscale(dmid),
    .conversion_active(busy), .settling_wait(settle));
  adcc_conv_model adcc_conv_model_i (.clk(clk), .conv_start(start), .current_channel(chan),
    .conv_done(done), .conv_result(res));
  // A read compares the byte returned with d; a write sends d.
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(negedge clk) {addr, wdata, wr, rd} = {a, d, w, !w};
    @(negedge clk) {wr, rd} = 2'b00;
    if (!w) chk("rdata", {8'h00, d}, {8'h00, rdata});
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    fail_count += int'(g !== e);
    if (g !== e) $display("wrong value %s expected %h seen %h", s, e, g);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    acc(1'b1, 2'h2, 8'h52);
    acc(1'b1, 2'h1, 8'hff);
    acc(1'b0, 2'h2, 8'h52);
    acc(1'b1, 2'h3, 8'hfb);
    acc(1'b0, 2'h3, 8'h63);
    repeat (1100) if (settle) @(negedge clk);
    chk("settle", 16'h0000, {15'h0000, settle});
    chk("gain", 16'h0003, {14'h0000, gain});
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 2'h0, 8'h80);
      repeat (50) if (busy) @(negedge clk);
      acc(1'b0, 2'h1, {4'(2 + i % 4), 4'h3});
    end
    acc(1'b0, 2'h0, 8'hc5);
    acc(1'b1, 2'h2, 8'h52);
    acc(1'b1, 2'h3, 8'h04);
    repeat (1100) if (settle) @(negedge clk);
    acc(1'b1, 2'h0, 8'h80);
    repeat (100) if (busy) @(negedge clk);
    acc(1'b0, 2'h1, 8'h53);
    chk("channel", 16'h0002, {12'h000, chan});
    chk("count", 16'h0009, {10'h000, count});
    $display("scan test done");
    rset = 4'hf;
    @(negedge clk) rset = 4'h0;
    acc(1'b1, 2'h0, 8'h15);
    chk("flags", 16'h000a, {12'h000, flags});
    chk("count", 16'h0000, {10'h000, count});
    irq = 1'b1;
    acc(1'b1, 2'h0, 8'h80);
    chk("busy", 16'h0000, {15'h0000, busy});
    acc(1'b1, 2'h0, 8'h20);
    chk("dac reset", 16'h0003, {14'h0000, drst, dmid});
    chk("channel", 16'h0002, {12'h000, chan});
    acc(1'b1, 2'h0, 8'h40);
    chk("board reset", 16'h0001, {15'h0000, brst});
    acc(1'b0, 2'h2, 8'h00);
    chk("gain", 16'h0000, {14'h0000, gain});
    $display("command test done");
    tally_and_finish;
  end
endmodule // adcc_ctrl_tb
`default_nettype wire
